/* src/cpmd_decode.sv */
// dual-function configuration pin decoder
`include "cpmd_defines.svh"

module cpmd_decode (
    // clock and reset
    input  wire logic                    clk,
    input  wire logic                    rst,
    // pins
    input  wire logic                    mgmt_iface_select,
    input  wire logic                    bus_width_select,
    input  wire logic                    clock_mode_select_in,
    output logic                         clock_mode_select_out,
    output logic                         clock_mode_select_oe,
    input  wire logic                    latch_edge_pin,
    input  wire logic                    deskew_enable_pin,
    input  wire logic [2:0]              deskew_trim_inputs,
    input  wire logic                    vref_low_swing,
    // management side settings and data drive
    input  wire logic                    mgmt_sda_pull_low,
    input  wire logic                    mgmt_deskew_enable,
    input  wire logic [2:0]              mgmt_deskew_trim,
    input  wire logic                    mgmt_bus_24bit,
    input  wire logic                    mgmt_clock_diff,
    input  wire logic                    mgmt_latch_rising,
    // decoded outputs
    output cpmd_pkg::cpmd_cfg_t          cfg,
    output cpmd_pkg::cpmd_i2c_pins_t     i2c_pins,
    output logic                         mgmt_active,
    output logic                         mgmt_state_reset
);
    localparam int NSYNC = 8;

    logic [NSYNC-1:0] pin_raw;
    logic [NSYNC-1:0] pin_s;
    cpmd_pkg::cpmd_mode_t     mode_reg;
    cpmd_pkg::cpmd_mode_t     mode_next;
    cpmd_pkg::cpmd_cfg_t      cfg_reg;
    cpmd_pkg::cpmd_cfg_t      cfg_next;
    cpmd_pkg::cpmd_i2c_pins_t i2c_reg;
    cpmd_pkg::cpmd_i2c_pins_t i2c_next;
    logic                     oe_reg;
    logic                     oe_next;
    logic                     rst_pulse_reg;
    logic                     mgmt_active_reg;
    logic                     mgmt_active_next;

    assign pin_raw = {vref_low_swing, deskew_trim_inputs, deskew_enable_pin,
                      latch_edge_pin, clock_mode_select_in, bus_width_select};

    // pins cross into the clock domain before any decode
    cpmd_sync #(.WIDTH(NSYNC)) u_sync (
        .clk      (clk),
        .rst      (rst),
        .async_in ({pin_raw[NSYNC-1:1], pin_raw[0]}),
        .sync_out (pin_s)
    );

    // select is synchronised separately to judge the mode first
    logic sel_meta_reg;
    logic sel_reg;
    always_ff @(posedge clk) begin
        if (rst) begin
            sel_meta_reg <= 1'b0;
            sel_reg      <= 1'b0;
        end else begin
            sel_meta_reg <= mgmt_iface_select;
            sel_reg      <= sel_meta_reg;
        end
    end

    wire       s_width    = pin_s[0];
    wire       s_cmode    = pin_s[1];
    wire       s_latch    = pin_s[2];
    wire       s_deskew_enable_pin     = pin_s[3];
    wire [2:0] s_trim     = pin_s[6:4];
    wire       s_vref_low = pin_s[7];

    // mode sequencing: leaving strap mode passes through a reset state
    always_comb begin
        mode_next = mode_reg;
        case (mode_reg)
            cpmd_pkg::CPMD_STRAP: begin
                if (sel_reg) begin
                    mode_next = cpmd_pkg::CPMD_MGMT_RESET;
                end
            end
            cpmd_pkg::CPMD_MGMT_RESET: begin
                mode_next = sel_reg ? cpmd_pkg::CPMD_MGMT : cpmd_pkg::CPMD_STRAP;
            end
            cpmd_pkg::CPMD_MGMT: begin
                if (!sel_reg) begin
                    mode_next = cpmd_pkg::CPMD_STRAP;
                end
            end
            default: mode_next = cpmd_pkg::CPMD_STRAP;
        endcase
    end

    wire in_mgmt = (mode_reg == cpmd_pkg::CPMD_MGMT) && sel_reg;
    wire in_rst  = (mode_reg == cpmd_pkg::CPMD_MGMT_RESET);

    assign mgmt_active_next = (mode_next == cpmd_pkg::CPMD_MGMT);

    // strap decode
    wire strap_diff   = s_cmode & ~s_width & s_vref_low;
    wire [2:0] strap_trim = s_deskew_enable_pin ? s_trim : `CPMD_TRIM_DEFAULT;

    always_comb begin
        cfg_next = '0;
        cfg_next.deskew_trim = `CPMD_TRIM_DEFAULT;
        if (!sel_reg) begin
            cfg_next.bus_24bit_single_edge = s_width;
            cfg_next.clock_differential    = strap_diff;
            cfg_next.latch_rising          = s_latch;
            cfg_next.deskew_on             = s_deskew_enable_pin;
            cfg_next.deskew_trim           = strap_trim;
        end else if (in_mgmt) begin
            cfg_next.bus_24bit_single_edge = mgmt_bus_24bit;
            cfg_next.clock_differential    = mgmt_clock_diff;
            cfg_next.latch_rising          = mgmt_latch_rising;
            cfg_next.deskew_on             = mgmt_deskew_enable;
            cfg_next.deskew_trim           = mgmt_deskew_enable ? mgmt_deskew_trim
                                                                : `CPMD_TRIM_DEFAULT;
        end
    end

    always_comb begin
        i2c_next = '1;
        if (in_mgmt) begin
            i2c_next.scl_in = s_width;
            i2c_next.sda_in = s_cmode;
            i2c_next.hpd_in = s_latch;
        end else begin
            i2c_next.hpd_in = 1'b0;
        end
    end

    assign oe_next = in_mgmt & mgmt_sda_pull_low;

    always_ff @(posedge clk) begin
        if (rst) begin
            mode_reg      <= cpmd_pkg::CPMD_STRAP;
            cfg_reg       <= '0;
            i2c_reg       <= 3'h6;
            oe_reg        <= 1'b0;
            rst_pulse_reg <= 1'b0;
            mgmt_active_reg <= 1'b0;
        end else begin
            mode_reg      <= mode_next;
            cfg_reg       <= cfg_next;
            i2c_reg       <= i2c_next;
            oe_reg        <= oe_next;
            rst_pulse_reg <= in_rst | ~sel_reg;
            mgmt_active_reg <= mgmt_active_next;
        end
    end

    assign clock_mode_select_out = 1'b0;
    assign clock_mode_select_oe  = oe_reg;
    assign cfg                   = cfg_reg;
    assign i2c_pins              = i2c_reg;
    assign mgmt_active           = mgmt_active_reg;
    assign mgmt_state_reset      = rst_pulse_reg;

    // checks
    open_drain_a: assert property (@(posedge clk) disable iff (rst)
        clock_mode_select_oe |-> mgmt_active && !clock_mode_select_out)
        else $error("data pin driven outside management mode");
    width_strap_a: assert property (@(posedge clk) disable iff (rst)
        !sel_reg |=> cfg.bus_24bit_single_edge == $past(s_width))
        else $error("strap width decode wrong");
    latch_strap_a: assert property (@(posedge clk) disable iff (rst)
        !sel_reg |=> cfg.latch_rising == $past(s_latch))
        else $error("strap latch edge wrong");
    trim_strap_a: assert property (@(posedge clk) disable iff (rst)
        (!sel_reg && !s_deskew_enable_pin) |=> cfg.deskew_trim == `CPMD_TRIM_DEFAULT)
        else $error("default trim not applied");
    trim_pins_a: assert property (@(posedge clk) disable iff (rst)
        (!sel_reg && s_deskew_enable_pin) |=> cfg.deskew_on && cfg.deskew_trim == $past(s_trim))
        else $error("pin trim not applied");
    reset_pass_a: assert property (@(posedge clk) disable iff (rst)
        (mode_reg == cpmd_pkg::CPMD_STRAP && sel_reg)
            |=> mode_reg == cpmd_pkg::CPMD_MGMT_RESET ##1 mgmt_state_reset)
        else $error("management reset skipped");
    scl_route_a: assert property (@(posedge clk) disable iff (rst)
        in_mgmt |=> i2c_pins.scl_in == $past(s_width) && i2c_pins.hpd_in == $past(s_latch))
        else $error("serial clock or hot plug routing wrong");
    mgmt_width_a: assert property (@(posedge clk) disable iff (rst)
        in_mgmt |=> cfg.bus_24bit_single_edge == $past(mgmt_bus_24bit))
        else $error("width pin still selects width in management mode");
    sda_route_a: assert property (@(posedge clk) disable iff (rst)
        in_mgmt |=> i2c_pins.sda_in == $past(s_cmode))
        else $error("data line level not routed");
    mgmt_cfg_a: assert property (@(posedge clk) disable iff (rst)
        in_mgmt |=> cfg.deskew_on == $past(mgmt_deskew_enable))
        else $error("management deskew setting ignored");
    diff_strap_a: assert property (@(posedge clk) disable iff (rst)
        !sel_reg |=> cfg.clock_differential == $past(strap_diff))
        else $error("clock mode decode wrong");
    sel_first_a: assert property (@(posedge clk) disable iff (rst)
        !sel_reg |=> !mgmt_active)
        else $error("management mode with select low");

    enter_mgmt_c: cover property (@(posedge clk) disable iff (rst)
        !sel_reg ##1 sel_reg [*3] ##1 mgmt_active);
    sda_pull_c: cover property (@(posedge clk) disable iff (rst) clock_mode_select_oe);
    strap_deskew_c: cover property (@(posedge clk) disable iff (rst)
        !sel_reg && s_deskew_enable_pin);
    reset_pass_c: cover property (@(posedge clk) disable iff (rst) mgmt_state_reset && sel_reg);
    hot_plug_c: cover property (@(posedge clk) disable iff (rst) mgmt_active && i2c_pins.hpd_in);
endmodule : cpmd_decode

/* src/cpmd_defines.svh */
// timing counts, trim field width and default trim value for the config pin decoder
`ifndef CPMD_DEFINES_SVH
`define CPMD_DEFINES_SVH
`define CPMD_TRIM_W          3
`define CPMD_TRIM_DEFAULT    3'h3
`define CPMD_SYNC_STAGES     2
`define CPMD_MODE_REUSE_CYC  2
`endif

/* src/cpmd_pkg.sv */
// types shared by the config pin decoder
package cpmd_pkg;
    typedef enum logic [1:0] {
        CPMD_STRAP,
        CPMD_MGMT_RESET,
        CPMD_MGMT
    } cpmd_mode_t;

    typedef struct packed {
        logic       bus_24bit_single_edge;
        logic       clock_differential;
        logic       latch_rising;
        logic       deskew_on;
        logic [2:0] deskew_trim;
    } cpmd_cfg_t;

    typedef struct packed {
        logic scl_in;
        logic sda_in;
        logic hpd_in;
    } cpmd_i2c_pins_t;
endpackage : cpmd_pkg

/* src/cpmd_sync.sv */
// two flip-flop synchroniser, one per bit
module cpmd_sync #(
    parameter int WIDTH = 8
) (
    // clock and reset
    input  wire logic             clk,
    input  wire logic             rst,
    // data
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] meta_reg;
    logic [WIDTH-1:0] sync_reg;

    // refuse a synchroniser with no bits at elaboration
    generate
        if (WIDTH < 1) begin : g_width_check
            $error("cpmd_sync: WIDTH must be at least 1");
        end
    endgenerate

    genvar i;
    generate
        for (i = 0; i < WIDTH; i++) begin : g_bit
            always_ff @(posedge clk) begin
                if (rst) begin
                    meta_reg[i] <= 1'b0;
                    sync_reg[i] <= 1'b0;
                end else begin
                    meta_reg[i] <= async_in[i];
                    sync_reg[i] <= meta_reg[i];
                end
            end
        end
    endgenerate

    assign sync_out = sync_reg;
endmodule : cpmd_sync

/* tb/cpmd_host_model.sv */
// far side of the data line: host pull-down plus board pull-up
module cpmd_host_model (
    // device side of the pin
    input  wire logic dut_oe,
    input  wire logic dut_out,
    // host side of the pin
    input  wire logic host_pull,
    output logic      sda_level
);
    timeunit 1ns;
    timeprecision 1ps;
    // open drain: low while either party pulls, else the pull-up wins
    assign sda_level = !((dut_oe && !dut_out) || host_pull);
endmodule : cpmd_host_model

/* tb/config_pin_mode_decode_tb_top.sv */
// self-checking bench for the config pin decoder
`include "cpmd_defines.svh"
`define CPMD_CHK(got, exp) begin check_count++; if ((got) !== (exp)) begin miscompares++; \
    $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp); end end

module config_pin_mode_decode_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic                     clk, rst, sel, bw, host_pull, lep, den, vref;
    logic                     pull, mden, m24, mdiff, mlatch, sda_level, oe, sda_out;
    logic                     active, state_rst;
    logic [2:0]               trim, mtrim;
    logic [12:0]              exp_v;
    logic [12:0]              exp_q[$];
    cpmd_pkg::cpmd_cfg_t      cfg;
    cpmd_pkg::cpmd_i2c_pins_t pins;
    event                     chk_ev;
    int                       miscompares, check_count, cycles, seed;

    cpmd_decode cpmd_decode_inst (.clk(clk), .rst(rst), .mgmt_iface_select(sel),
        .bus_width_select(bw), .clock_mode_select_in(sda_level),
        .clock_mode_select_out(sda_out), .clock_mode_select_oe(oe), .latch_edge_pin(lep),
        .deskew_enable_pin(den), .deskew_trim_inputs(trim), .vref_low_swing(vref),
        .mgmt_sda_pull_low(pull), .mgmt_deskew_enable(mden), .mgmt_deskew_trim(mtrim),
        .mgmt_bus_24bit(m24), .mgmt_clock_diff(mdiff), .mgmt_latch_rising(mlatch),
        .cfg(cfg), .i2c_pins(pins), .mgmt_active(active), .mgmt_state_reset(state_rst));

    cpmd_host_model cpmd_host_model_inst (.dut_oe(oe), .dut_out(sda_out),
        .host_pull(host_pull), .sda_level(sda_level));

    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    // expected {cfg, pins, active, state reset, oe} from the pin levels and management settings
    function automatic logic [12:0] expected();
        logic [2:0] t;
        if (!sel) begin
            t = den ? trim : `CPMD_TRIM_DEFAULT;
            return {bw, !host_pull & !bw & vref, lep, den, t, 3'h6, 1'b0, 1'b1, 1'b0};
        end
        t = mden ? mtrim : `CPMD_TRIM_DEFAULT;
        return {m24, mdiff, mlatch, mden, t, bw, !(pull | host_pull), lep, 1'b1, 1'b0, pull};
    endfunction : expected

    task automatic step(input logic s);
        logic [31:0] r;
        r = $random(seed);
        @(negedge clk);
        sel = s;
        {bw, host_pull, lep, den, vref, pull, mden, m24, mdiff, mlatch} = r[9:0];
        trim = r[12:10];
        mtrim = r[15:13];
        repeat (8) @(negedge clk);
        exp_q.push_back(expected());
        -> chk_ev;
    endtask : step

    task automatic complete_run();
        $display("checks %0d mismatches %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : complete_run

    always @(chk_ev) begin
        exp_v = exp_q.pop_front();
        `CPMD_CHK({cfg, pins, active, state_rst, oe}, exp_v)
        `CPMD_CHK(sda_out, 1'b0)
    end

    always @(posedge clk) begin
        cycles++;
        if (cycles == 1000) begin
            miscompares++;
            complete_run();
        end
    end

    initial begin
        seed = 36;
        {rst, sel, bw, host_pull, lep, den, vref, pull, mden, m24, mdiff, mlatch} = 12'h800;
        trim = 3'h0;
        mtrim = 3'h0;
        repeat (10) @(negedge clk);
        // outputs while reset is held: cfg zero, pins 110, all flags low
        exp_q.push_back(13'h0030);
        -> chk_ev;
        rst = 1'b0;
        // strap, management, strap again, then management after a select cycle
        for (int g = 0; g < 4; g++) begin
            for (int i = 0; i < 8; i++) begin
                step(g[0]);
            end
            $display("test %0d done, management mode %0d", g, g[0]);
        end
        repeat (2) @(negedge clk);
        complete_run();
    end
endmodule : config_pin_mode_decode_tb_top
